// *** design/instr_unit_exception_logic.sv ***
// Purpose: recognise, rank and dispatch instruction-unit exceptions
// Assumes: decode stage holds an instruction until instrDone pulses
// Notes:   request line sampled on falling edges, everything else on rising
`include "instr_exc_map.svh"

module instr_unit_exception_logic #(
  parameter int MEM_D_LAT = 1,
  parameter int MEM_I_LAT = 1
) (
  input  wire  logic                       clock,
  input  wire  logic                       rst,
  // Avalon-MM slave
  input  wire  logic [4:0]                 avs_address,
  input  wire  logic                       avs_read,
  input  wire  logic                       avs_write,
  input  wire  logic [31:0]                avs_writedata,
  input  wire  logic [3:0]                 avs_byteenable,
  output logic       [31:0]                avs_readdata,
  output logic                             avs_waitrequest,
  // interrupt line, active high level
  input  wire  logic                       irqReq,
  // decode stage
  input  wire  logic                       instrValid,
  input  wire  logic [31:0]                instrAddr,
  input  wire  instr_exc_pkg::instr_kind_t instrKind,
  input  wire  instr_exc_pkg::acc_size_t   accSize,
  input  wire  logic [31:0]                accAddr,
  input  wire  logic [4:0]                 destReg,
  input  wire  logic                       unimplOp,
  input  wire  logic                       unitOp,
  input  wire  logic                       userOption,
  input  wire  logic                       ctrlIsFloat,
  input  wire  logic [7:0]                 trapVec,
  input  wire  logic                       condTrue,
  input  wire  logic [31:0]                trapOperand,
  input  wire  logic [4:0]                 trapBit,
  input  wire  logic [31:0]                bndValue,
  input  wire  logic [31:0]                bndLimit,
  // machine state
  input  wire  logic [31:0]                scoreboard,
  input  wire  logic [2:0]                 dataPending,
  input  wire  logic                       prefetchBusy,
  input  wire  logic                       rteDone,
  // results
  output logic                             instrDone,
  output logic                             suppress,
  output logic [31:0]                      alignedAddr,
  output logic                             sbSetValid,
  output logic [4:0]                       sbSetReg,
  output logic                             excTake,
  output logic [11:0]                      excOffset,
  output logic [31:0]                      excFetchAddr,
  output logic                             unitExcTake
);
  import instr_exc_pkg::*;

  localparam int LAT_WORST = `LAT_FIXED + MEM_I_LAT +
                             ((`LAT_DATA_MULT * MEM_D_LAT > MEM_I_LAT) ?
                              `LAT_DATA_MULT * MEM_D_LAT : MEM_I_LAT);

  typedef enum logic [1:0] {S_RUN, S_DRAIN, S_DONE} state_t;

  // ********************************
  // state
  // ********************************
  logic [31:0] status_r;
  logic [31:0] excStatus_r;
  logic [31:0] shadowXp_r;
  logic [31:0] shadowSb_r;
  logic [31:0] vecBase_r;
  logic [11:0] lastOffset_r;
  logic [15:0] latCount_r;
  logic [31:0] lastAddr_r;
  logic        irqSample_r;
  logic        irqSeen_r;
  logic        holdOne_r;
  logic        waitReq_r;
  logic [31:0] rdata_r;
  state_t      state_r;
  logic        instrDone_r;
  logic        suppress_r;
  logic [31:0] alignedAddr_r;
  logic        sbSetValid_r;
  logic [4:0]  sbSetReg_r;
  logic        excTake_r;
  logic [11:0] excOffset_r;
  logic [31:0] excFetchAddr_r;
  logic        unitExcTake_r;

  // ********************************
  // interrupt sampling
  // ********************************
  // falling-edge pair: one sample, one internal signalling edge
  always_ff @(negedge clock) begin
    if (rst) begin
      irqSample_r <= 1'b0;
      irqSeen_r   <= 1'b0;
    end else begin
      irqSample_r <= irqReq;
      irqSeen_r   <= irqSample_r;
    end
  end

  // ********************************
  // decode checks
  // ********************************
  logic        isUser;
  logic        isMem;
  logic        isTrap;
  logic        misaligned;
  logic        privFault;
  logic        trapTaken;
  logic        bndFault;
  logic        trapWait;
  logic        irqWanted;
  logic        accept;
  logic [31:0] sizeMask;
  logic [11:0] selOffset;
  logic        selExc;
  logic        selUnit;

  always_comb begin
    unique case (accSize)
      SZ_BYTE:  sizeMask = 32'h00000000;
      SZ_HALF:  sizeMask = 32'h00000001;
      SZ_WORD:  sizeMask = 32'h00000003;
      SZ_DWORD: sizeMask = 32'h00000007;
    endcase
  end

  always_comb begin
    isUser     = ~status_r[`BIT_SUPER];
    isMem      = (instrKind == K_LOAD) || (instrKind == K_STORE) || (instrKind == K_XCHG);
    isTrap     = (instrKind == K_TCND) || (instrKind == K_TB0) || (instrKind == K_TB1);
    misaligned = isMem && ((accAddr & sizeMask) != 32'h0) &&
                 ~status_r[`BIT_MIS_MASK];
    privFault  = isUser && (((instrKind == K_CTRL) && ~ctrlIsFloat) ||
                            (isMem && userOption) ||
                            (isTrap && trapVec < `TRAP_USER_MIN));
    unique case (instrKind)
      K_TCND:  trapTaken = condTrue;
      K_TB0:   trapTaken = ~trapOperand[trapBit];
      K_TB1:   trapTaken = trapOperand[trapBit];
      default: trapTaken = 1'b0;
    endcase
    bndFault   = (instrKind == K_TBND) && (bndValue > bndLimit);
    trapWait   = isTrap && ((scoreboard != 32'h0) || (dataPending != 3'h0));
    irqWanted  = irqSeen_r && ~status_r[`BIT_IRQ_DIS] && ~holdOne_r;
  end

  // fixed priority, most severe first
  always_comb begin
    selExc    = 1'b1;
    selUnit   = 1'b0;
    selOffset = 12'h000;
    if (unitOp && unimplOp) begin
      selExc  = 1'b0;
      selUnit = 1'b1;
    end else if (unimplOp) begin
      selOffset = `VEC_UNIMPL;
    end else if (privFault) begin
      selOffset = `VEC_PRIV;
    end else if (misaligned) begin
      selOffset = `VEC_MISALIGN;
    end else if (bndFault) begin
      selOffset = `VEC_BOUND;
    end else if (trapTaken) begin
      selOffset = {1'b0, trapVec, 3'b000};
    end else begin
      selExc = 1'b0;
    end
  end

  assign accept = instrValid && ~instrDone_r && (state_r == S_RUN) &&
                  ~irqWanted && ~trapWait;

  // ********************************
  // sequencing
  // ********************************
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r    <= S_RUN;
      latCount_r <= 16'h0000;
    end else begin
      unique case (state_r)
        S_RUN: begin
          if (irqWanted) begin
            state_r    <= S_DRAIN;
            latCount_r <= 16'h0001;
          end
        end
        S_DRAIN: begin
          latCount_r <= latCount_r + 16'h0001;
          // up to four data accesses plus a parallel prefetch must finish
          if (dataPending == 3'h0 && ~prefetchBusy) begin
            state_r <= S_DONE;
          end
        end
        S_DONE: begin
          state_r <= S_RUN;
        end
      endcase
    end
  end

  // ********************************
  // instruction results
  // ********************************
  always_ff @(posedge clock) begin
    if (rst) begin
      instrDone_r   <= 1'b0;
      suppress_r    <= 1'b0;
      alignedAddr_r <= 32'h00000000;
      sbSetValid_r  <= 1'b0;
      sbSetReg_r    <= 5'h00;
      unitExcTake_r <= 1'b0;
      lastAddr_r    <= 32'h00000000;
    end else begin
      instrDone_r   <= accept;
      suppress_r    <= accept && selExc;
      unitExcTake_r <= accept && selUnit;
      alignedAddr_r <= accAddr & ~sizeMask;
      sbSetValid_r  <= accept && ~unimplOp && (misaligned || privFault) &&
                       ((instrKind == K_LOAD) || (instrKind == K_XCHG));
      sbSetReg_r    <= destReg;
      if (accept) begin
        lastAddr_r <= instrAddr;
      end
    end
  end

  // ********************************
  // exception dispatch and shadow state
  // ********************************
  logic        takeInstr;
  logic        takeIrq;
  logic        frozen;
  logic [11:0] takeOffset;
  logic [31:0] bwr;

  always_comb begin
    frozen     = status_r[`BIT_FREEZE];
    takeInstr  = accept && selExc;
    takeIrq    = (state_r == S_DONE);
    takeOffset = takeIrq ? (frozen ? `VEC_ERROR : `VEC_IRQ) : selOffset;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      excTake_r      <= 1'b0;
      excOffset_r    <= 12'h000;
      excFetchAddr_r <= `RST_VEC_BASE;
      lastOffset_r   <= 12'h000;
    end else begin
      excTake_r <= takeInstr || takeIrq;
      if (takeInstr || takeIrq) begin
        excOffset_r    <= takeOffset;
        excFetchAddr_r <= vecBase_r + {20'h00000, takeOffset};
        lastOffset_r   <= takeOffset;
      end
    end
  end

  // shadow registers capture an exception only while unfrozen; bus writes still load excStatus_r and shadowSb_r
  always_ff @(posedge clock) begin
    if (rst) begin
      shadowXp_r  <= 32'h00000000;
      excStatus_r <= `RST_STATUS;
    end else if ((takeInstr || takeIrq) && ~frozen) begin
      shadowXp_r  <= takeIrq ? lastAddr_r : instrAddr;
      excStatus_r <= status_r;
    end else if (avs_write && ~waitReq_r && avs_address == `OFS_EXC_STATUS) begin
      excStatus_r <= merge(excStatus_r);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shadowSb_r <= 32'h00000000;
    end else if ((takeInstr || takeIrq) && ~frozen) begin
      shadowSb_r <= scoreboard;
    end else if (avs_write && ~waitReq_r && avs_address == `OFS_SHADOW_SB) begin
      shadowSb_r <= merge(shadowSb_r);
    end
  end

  // ********************************
  // status register
  // ********************************
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable[b]) begin
        res[b*8 +: 8] = avs_writedata[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // always_comb so that write data and byte lanes read inside merge are tracked too
  always_comb bwr = merge(status_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= `RST_STATUS;
    end else if (takeInstr || takeIrq) begin
      status_r[`BIT_FREEZE]  <= 1'b1;
      status_r[`BIT_IRQ_DIS] <= 1'b1;
      status_r[`BIT_SUPER]   <= 1'b1;
    end else if (rteDone) begin
      status_r <= excStatus_r;
    end else if (avs_write && ~waitReq_r && avs_address == `OFS_STATUS) begin
      status_r <= bwr;
    end
  end

  // a control store that re-enables interrupts holds them off one instruction
  always_ff @(posedge clock) begin
    if (rst) begin
      holdOne_r <= 1'b0;
    end else if (avs_write && ~waitReq_r && avs_address == `OFS_STATUS &&
                 status_r[`BIT_IRQ_DIS] && ~bwr[`BIT_IRQ_DIS]) begin
      holdOne_r <= 1'b1;
    end else if (accept || rteDone) begin
      holdOne_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      vecBase_r <= `RST_VEC_BASE;
    end else if (avs_write && ~waitReq_r && avs_address == `OFS_VEC_BASE) begin
      vecBase_r <= merge(vecBase_r) & 32'hfffff000;
    end
  end

  // ********************************
  // bus slave
  // ********************************
  // one wait cycle per access keeps read data registered
  always_ff @(posedge clock) begin
    if (rst) begin
      waitReq_r <= 1'b1;
      rdata_r   <= 32'h00000000;
    end else begin
      waitReq_r <= ~((avs_read || avs_write) && waitReq_r);
      unique case (avs_address)
        `OFS_STATUS:     rdata_r <= status_r;
        `OFS_EXC_STATUS: rdata_r <= excStatus_r;
        `OFS_SHADOW_XP:  rdata_r <= shadowXp_r;
        `OFS_SHADOW_SB:  rdata_r <= shadowSb_r;
        `OFS_VEC_BASE:   rdata_r <= vecBase_r;
        `OFS_CAUSE:      rdata_r <= {latCount_r, 4'h0, lastOffset_r};
        default:         rdata_r <= 32'h00000000;
      endcase
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = waitReq_r;
  assign instrDone       = instrDone_r;
  assign suppress        = suppress_r;
  assign alignedAddr     = alignedAddr_r;
  assign sbSetValid      = sbSetValid_r;
  assign sbSetReg        = sbSetReg_r;
  assign excTake         = excTake_r;
  assign excOffset       = excOffset_r;
  assign excFetchAddr    = excFetchAddr_r;
  assign unitExcTake     = unitExcTake_r;
endmodule : instr_unit_exception_logic

// *** shared/instr_exc_map.svh ***
`ifndef INSTR_EXC_MAP_SVH
`define INSTR_EXC_MAP_SVH
// Purpose: offsets, field positions, reset values and vector offsets
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes:   the offsets, bit positions, reset, vector and latency figures of the exception unit live here

// register byte offsets
`define OFS_STATUS      5'h00
`define OFS_EXC_STATUS  5'h04
`define OFS_SHADOW_XP   5'h08
`define OFS_SHADOW_SB   5'h0c
`define OFS_VEC_BASE    5'h10
`define OFS_CAUSE       5'h14

// status register bits
`define BIT_FREEZE      0
`define BIT_IRQ_DIS     1
`define BIT_MIS_MASK    2
`define BIT_SUPER       31

// reset values: supervisor, frozen, interrupts disabled
`define RST_STATUS      32'h80000003
`define RST_VEC_BASE    32'h00000000

// vector offsets
`define VEC_IRQ         12'h008
`define VEC_MISALIGN    12'h020
`define VEC_UNIMPL      12'h028
`define VEC_PRIV        12'h030
`define VEC_BOUND       12'h038
`define VEC_ERROR       12'h3f8
`define TRAP_USER_MIN   8'h80

// interrupt latency figures
`define LAT_FIXED       3
`define LAT_DATA_MULT   4
`endif

// *** shared/instr_exc_pkg.sv ***
// Purpose: types shared by the exception unit and its bench
// Assumes: nothing beyond the map header
// Notes:   instruction classes as presented by the decode stage
package instr_exc_pkg;
  typedef enum logic [3:0] {
    K_NONE, K_LOAD, K_STORE, K_XCHG, K_TCND, K_TB0, K_TB1, K_TBND, K_CTRL, K_OTHER
  } instr_kind_t;

  typedef enum logic [1:0] {
    SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD
  } acc_size_t;
endpackage : instr_exc_pkg

// *** verif/instr_unit_exception_logic_asserts.sv ***
// Purpose: port-level checks for the exception unit
// Assumes: bound to the unit; one clock domain at its ports
// Notes:   decode results appear one cycle after acceptance
`include "instr_exc_map.svh"
module instr_unit_exception_logic_asserts (
  input wire logic                       clock,
  input wire logic                       rst,
  input wire instr_exc_pkg::acc_size_t   accSize,
  input wire logic [31:0]                accAddr,
  input wire instr_exc_pkg::instr_kind_t instrKind,
  input wire logic [4:0]                 destReg,
  input wire logic [31:0]                scoreboard,
  input wire logic [2:0]                 dataPending,
  input wire logic                       prefetchBusy,
  input wire logic                       instrDone,
  input wire logic                       suppress,
  input wire logic [31:0]                alignedAddr,
  input wire logic                       sbSetValid,
  input wire logic [4:0]                 sbSetReg,
  input wire logic                       excTake,
  input wire logic [11:0]                excOffset,
  input wire logic [31:0]                excFetchAddr,
  input wire logic                       unitExcTake
);
  timeunit 1ns;
  timeprecision 1ns;
  import instr_exc_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_sup_done: assert property (suppress |-> instrDone)
    else $error("suppress without done");
  a_align_round: assert property (!$past(rst) |->
    alignedAddr == (($past(accAddr) >> $past(accSize)) << $past(accSize)))
    else $error("address not rounded to size");
  a_fetch_base: assert property (excTake |-> excFetchAddr[11:0] == excOffset)
    else $error("fetch address not base plus offset");
  a_irq_vector: assert property (excTake && !instrDone |->
    excOffset inside {`VEC_IRQ, `VEC_ERROR})
    else $error("interrupt offset wrong");
  a_trap_wait: assert property (instrDone &&
    $past(instrKind) inside {K_TCND, K_TB0, K_TB1} |->
    $past(scoreboard) == 32'h0 && $past(dataPending) == 3'h0)
    else $error("trap ran before machine idle");
  a_drain_first: assert property (excTake && !instrDone |->
    $past(dataPending, 2) == 3'h0 && !$past(prefetchBusy, 2))
    else $error("interrupt before drain");
  a_sb_dest: assert property (sbSetValid |->
    instrDone && sbSetReg == $past(destReg))
    else $error("scoreboard set wrong");
  a_unit_alone: assert property (unitExcTake |-> !excTake)
    else $error("unit and offset exception together");
endmodule : instr_unit_exception_logic_asserts

// *** verif/irq_source_model.sv ***
// Purpose: outside interrupt controller on the single request line
// Assumes: bench raises and acknowledges on rising edges
// Notes:   level stays up until acknowledged, never self-clears
module irq_source_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic raise,
  input  wire logic ack,
  output logic      irqReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // request level
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst || ack) begin
      irqReq <= 1'h0;
    end else if (raise) begin
      irqReq <= 1'h1;
    end
  end
endmodule : irq_source_model

// *** verif/test_instr_unit_exception_logic.sv ***
// Purpose: self-checking bench for the exception unit
// Assumes: one 20 MHz clock, synchronous reset, no random stimulus
// Notes:   every drive is a non-blocking update at a rising edge
`include "instr_exc_map.svh"
module test_instr_unit_exception_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import instr_exc_pkg::*;
  localparam int DLAT = 1;
  localparam int ILAT = 1;
  localparam int LATMAX = `LAT_FIXED + ILAT +
                          ((`LAT_DATA_MULT * DLAT > ILAT) ? `LAT_DATA_MULT * DLAT : ILAT);
  localparam logic [31:0] BASE = 32'h00001000;
  logic clock, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, instrValid = 1'h0, unimplOp = 1'h0;
  logic unitOp = 1'h0, userOption = 1'h0, ctrlIsFloat = 1'h0, condTrue = 1'h0, rteDone = 1'h0;
  logic prefetchBusy = 1'h0, raise = 1'h0, ack = 1'h0, cExc, cSb, cSup, cUnit;
  logic [4:0]  avs_address = 5'h0, destReg = 5'h0, trapBit = 5'h0, sbSetReg;
  logic [31:0] avs_writedata = 32'h0, instrAddr = 32'h0, accAddr = 32'h0, trapOperand = 32'h0;
  logic [31:0] bndValue = 32'h0, bndLimit = 32'h0, scoreboard = 32'h0, q, s0;
  logic [31:0] avs_readdata, alignedAddr, excFetchAddr;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [7:0]  trapVec = 8'h0;
  logic [2:0]  dataPending = 3'h0;
  logic [11:0] excOffset, cOff;
  logic        avs_waitrequest, irqReq, instrDone, suppress, sbSetValid, excTake, unitExcTake;
  instr_kind_t instrKind = K_NONE;
  acc_size_t   accSize = SZ_BYTE;
  int          n_mismatch = 0, n_checks = 0, lat;
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  irq_source_model src (.clock(clock), .rst(rst), .raise(raise), .ack(ack), .irqReq(irqReq));
  instr_unit_exception_logic #(.MEM_D_LAT(DLAT), .MEM_I_LAT(ILAT)) dut (
    .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .irqReq, .instrValid, .instrAddr, .instrKind,
    .accSize, .accAddr, .destReg, .unimplOp, .unitOp, .userOption, .ctrlIsFloat,
    .trapVec, .condTrue, .trapOperand, .trapBit, .bndValue, .bndLimit, .scoreboard,
    .dataPending, .prefetchBusy, .rteDone, .instrDone, .suppress, .alignedAddr,
    .sbSetValid, .sbSetReg, .excTake, .excOffset, .excFetchAddr, .unitExcTake);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic lost;
    n_mismatch++;
    $display("[ERR] %0t wait ran out", $time);
    finish_test();
  endtask : lost
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'h0) break;
    end
    if (i == 20) lost();
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clock);
  endtask : bus
  task automatic issue(input instr_kind_t k, input acc_size_t s, input logic [31:0] a);
    int i;
    instrKind <= k;
    accSize <= s;
    accAddr <= a;
    instrAddr <= instrAddr + 32'h4;
    instrValid <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (instrDone === 1'h1) break;
    end
    if (i == 40) lost();
    cExc = excTake;
    cOff = excOffset;
    cSb = sbSetValid;
    cSup = suppress;
    cUnit = unitExcTake;
    instrValid <= 1'h0;
    @(posedge clock);
  endtask : issue
  task automatic exp_exc(input logic e, input logic [11:0] off);
    chk(cExc, e);
    if (e) chk(cOff, off);
  endtask : exp_exc
  task automatic wait_exc(input int n);
    for (lat = 0; lat < n; lat++) begin
      @(posedge clock);
      cExc = excTake;
      if (cExc === 1'h1) break;
    end
    cOff = excOffset;
  endtask : wait_exc
  task automatic ret;
    rteDone <= 1'h1;
    @(posedge clock);
    rteDone <= 1'h0;
    @(posedge clock);
  endtask : ret
  // the line must be seen low through the falling-edge pair before the return,
  // otherwise the still-pending level re-enters at once
  task automatic ack_irq;
    ack <= 1'h1;
    raise <= 1'h0;
    repeat (3) @(posedge clock);
    ack <= 1'h0;
    ret();
  endtask : ack_irq
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_decode;
    instr_kind_t k[6] = '{K_LOAD, K_STORE, K_XCHG, K_LOAD, K_LOAD, K_STORE};
    acc_size_t   s[6] = '{SZ_HALF, SZ_WORD, SZ_WORD, SZ_DWORD, SZ_DWORD, SZ_BYTE};
    logic [31:0] a[6] = '{32'h401, 32'h402, 32'h403, 32'h404, 32'h408, 32'h401};
    instr_kind_t p[5] = '{K_CTRL, K_CTRL, K_LOAD, K_TCND, K_TCND};
    for (int j = 0; j < 6; j++) begin
      destReg <= 5'(j + 3);
      issue(k[j], s[j], a[j]);
      exp_exc(j < 4, `VEC_MISALIGN);
      if (j < 4) begin
        chk(cSb, k[j] != K_STORE);
        chk(excFetchAddr, BASE + 32'h20);
        bus(1'h0, `OFS_SHADOW_XP, 32'h0);
        chk(q, instrAddr);
        ret();
      end
    end
    bus(1'h1, `OFS_STATUS, 32'h80000004);
    issue(K_LOAD, SZ_HALF, 32'h401);
    exp_exc(1'h0, 12'h0);
    chk(alignedAddr, 32'h400);
    unimplOp <= 1'h1;
    issue(K_OTHER, SZ_WORD, 32'h0);
    exp_exc(1'h1, `VEC_UNIMPL);
    ret();
    unitOp <= 1'h1;
    issue(K_OTHER, SZ_WORD, 32'h0);
    chk({cUnit, cExc}, 2'h2);
    unitOp <= 1'h0;
    unimplOp <= 1'h0;
    ret();
    bus(1'h1, `OFS_STATUS, 32'h00000000);
    for (int j = 0; j < 5; j++) begin
      ctrlIsFloat <= j == 1;
      userOption <= j == 2;
      trapVec <= (j == 4) ? 8'h80 : 8'h7f;
      condTrue <= 1'h1;
      issue(p[j], SZ_WORD, 32'h0);
      exp_exc(j != 1, (j == 4) ? 12'h400 : `VEC_PRIV);
      chk(cSup, j != 1);
      if (j == 2) chk(cSb, 1'h1);
      if (j != 1) ret();
    end
    userOption <= 1'h0;
  endtask : t_decode
  task automatic t_trap;
    instr_kind_t k[4] = '{K_TCND, K_TB1, K_TB0, K_TB0};
    bus(1'h1, `OFS_STATUS, 32'h80000000);
    trapBit <= 5'h3;
    for (int j = 0; j < 4; j++) begin
      trapVec <= 8'hff - 8'(j);
      trapOperand <= (j == 1 || j == 2) ? 32'h8 : 32'h0;
      issue(k[j], SZ_WORD, 32'h0);
      exp_exc(j != 2, {1'h0, 8'hff - 8'(j), 3'h0});
      if (j != 2) ret();
    end
    scoreboard <= 32'h1;
    dataPending <= 3'h1;
    condTrue <= 1'h0;
    fork
      issue(K_TCND, SZ_WORD, 32'h0);
      begin
        repeat (6) begin
          @(posedge clock);
          chk(instrDone, 1'h0);
        end
        scoreboard <= 32'h0;
        dataPending <= 3'h0;
      end
    join
    exp_exc(1'h0, 12'h0);
    bus(1'h0, `OFS_SHADOW_XP, 32'h0);
    s0 = q;
    bus(1'h1, `OFS_STATUS, 32'h80000001);
    condTrue <= 1'h1;
    trapVec <= 8'h90;
    issue(K_TCND, SZ_WORD, 32'h0);
    exp_exc(1'h1, 12'h480);
    bus(1'h0, `OFS_SHADOW_XP, 32'h0);
    chk(q, s0);
    bus(1'h1, `OFS_STATUS, 32'h80000000);
    for (int j = 0; j < 2; j++) begin
      bndValue <= j ? 32'h10 : 32'h80000000;
      bndLimit <= 32'h10;
      issue(K_TBND, SZ_WORD, 32'h0);
      exp_exc(j == 0, `VEC_BOUND);
      if (j == 0) ret();
    end
  endtask : t_trap
  task automatic t_irq;
    bus(1'h1, `OFS_STATUS, 32'h80000002);
    raise <= 1'h1;
    wait_exc(10);
    chk(cExc, 1'h0);
    bus(1'h1, `OFS_STATUS, 32'h80000000);
    wait_exc(10);
    chk(cExc, 1'h0);
    dataPending <= 3'h2;
    prefetchBusy <= 1'h1;
    issue(K_OTHER, SZ_WORD, 32'h0);
    wait_exc(6);
    chk(cExc, 1'h0);
    dataPending <= 3'h0;
    prefetchBusy <= 1'h0;
    wait_exc(20);
    exp_exc(1'h1, `VEC_IRQ);
    chk(lat <= LATMAX, 1'h1);
    chk(excFetchAddr, BASE + 32'h8);
    bus(1'h0, `OFS_SHADOW_XP, 32'h0);
    chk(q, instrAddr);
    ack_irq();
    bus(1'h1, `OFS_STATUS, 32'h80000001);
    raise <= 1'h1;
    wait_exc(20);
    exp_exc(1'h1, `VEC_ERROR);
    bus(1'h1, `OFS_EXC_STATUS, 32'h80000000);
    ret();
    wait_exc(20);
    exp_exc(1'h1, `VEC_IRQ);
    ack_irq();
    wait_exc(10);
    chk(cExc, 1'h0);
  endtask : t_irq
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk(q, `RST_STATUS);
    bus(1'h0, 5'h18, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, `OFS_VEC_BASE, BASE);
    bus(1'h1, `OFS_STATUS, 32'h80000000);
    t_decode();
    t_trap();
    t_irq();
    finish_test();
  end
endmodule : test_instr_unit_exception_logic
bind instr_unit_exception_logic instr_unit_exception_logic_asserts u_chk (
  .clock, .rst, .accSize, .accAddr, .instrKind, .destReg, .scoreboard, .dataPending,
  .prefetchBusy, .instrDone, .suppress, .alignedAddr, .sbSetValid, .sbSetReg, .excTake,
  .excOffset, .excFetchAddr, .unitExcTake);
